// file: common/bcs_regs.vh
`ifndef BCS_REGS_VH
`define BCS_REGS_VH
// ----------------------------------------
// timing
// ----------------------------------------
`define BCS_CLK_PERIOD_NS 20
`define BCS_TICK_NS 1000000
`define BCS_IRQ_PULSE_NS 256000
`define BCS_TERM_DGL_MS 8'hFA
`define BCS_RECH_DGL_MS 8'h64
`define BCS_MS_PER_S 10'h3E8
`define BCS_PRE_TIMER_S 16'h1C20
`define BCS_TMR_SEL1_S 16'h4650
`define BCS_TMR_SEL2_S 16'h7080
`define BCS_TMR_SEL3_S 16'hA8C0
`define BCS_TOP1_S 12'h384
`define BCS_TOP2_S 12'h708
`define BCS_TOP3_S 12'hA8C
// ----------------------------------------
// register offsets
// ----------------------------------------
`define BCS_ADDR_CTRL 4'h0
`define BCS_ADDR_TIMER 4'h1
`define BCS_ADDR_THERM 4'h2
`define BCS_ADDR_THRESH 4'h3
`define BCS_ADDR_ZONESET 4'h4
`define BCS_ADDR_STATUS 4'h5
`define BCS_ADDR_ZONES 4'h6
`define BCS_ADDR_MASK 4'h7
// ----------------------------------------
// field positions
// ----------------------------------------
`define BCS_CTRL_CHG_EN 0
`define BCS_CTRL_BUCK_EN 1
`define BCS_CTRL_TERM_EN 2
`define BCS_CTRL_TMR2X 3
`define BCS_CTRL_SW_DIS 4
`define BCS_CTRL_SEL_B 5
`define BCS_CTRL_REG_RST 6
`define BCS_THERM_A_ACT 0
`define BCS_THERM_B_ACT 1
`define BCS_MASK_ILOOP 0
`define BCS_MASK_VLOOP 1
`define BCS_MASK_TOPOFF 2
// ----------------------------------------
// reset values
// ----------------------------------------
`define BCS_CTRL_RST 8'h0F
`define BCS_TIMER_RST 8'h01
`define BCS_THERM_RST 8'h01
`define BCS_THRESH_RST 8'h00
`define BCS_ZONESET_RST 8'h00
`define BCS_MASK_RST 8'h00
// ----------------------------------------
// codes
// ----------------------------------------
`define BCS_PH_IDLE 3'h0
`define BCS_PH_TRICKLE 3'h1
`define BCS_PH_PRE 3'h2
`define BCS_PH_CC 3'h3
`define BCS_PH_CV 3'h4
`define BCS_PH_DONE 3'h5
`define BCS_Z_NORMAL 3'h0
`define BCS_Z_WARM 3'h2
`define BCS_Z_COOL 3'h3
`define BCS_Z_COLD 3'h5
`define BCS_Z_HOT 3'h6
`define BCS_FAULT_NONE 2'h0
`define BCS_FAULT_TIMER 2'h2
`endif

// file: core/bcs_deglitch.v
`timescale 1ns/10ps
module bcs_deglitch (
   // clock and reset
   input wire clock,
   input wire rstn,
   // timebase and level
   input wire tick,
   input wire level,
   input wire [7:0] limit,
   output reg held
);
   reg [7:0] cnt;
   // ----------------------------------------
   // level must stay high for limit ticks; any drop restarts the count
   // ----------------------------------------
   always @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         cnt <= 8'h00;
         held <= 1'b0;
      end else if (!level) begin
         cnt <= 8'h00;
         held <= 1'b0;
      end else if (tick && cnt != limit) begin
         cnt <= cnt + 8'h01;
      end else if (cnt == limit) begin
         held <= 1'b1;
      end
   end
endmodule

// file: core/bcs_charge_seq.v
`timescale 1ns/10ps
`include "bcs_regs.vh"
// Function
// - input loop flags set, maskable interrupt follows
// - system below battery turns battery switch on
// - start needs converter, thermistors, switch, enable
// - phase code from battery voltage comparators
// - other loops block termination, halve timer
// - terminate on enable, deglitch, CV, no loops
// - termination writes 101, indicator high, interrupt
// - top-off runs, flagged, interrupts entry and exit
// - top-off reset on enable, recharge, reg reset
// - recharge after deglitch below threshold, interrupt
// - per-channel action bits, second channel selectable
// - out-of-window thermistor suspends charging
// - cool and warm zones reduce current/voltage
// - four-level thresholds shared by both channels
// - zones reported, interrupt on any change
// - merge priority hot, cold, warm, cool
// - boost checks cold/hot only, suspends boost
// - two hour precharge limit, 00 disables
// - timer expiry disables charge, fault 10, interrupt
// - half rate timer under regulation, disable bit
// - safety timer cleared on unplug, toggles, reset
// - events give 256us low interrupt pulses, merged while one runs
module bcs_charge_seq #(
   parameter TICK_CYCLES = `BCS_TICK_NS / `BCS_CLK_PERIOD_NS,
   parameter IRQ_CYCLES = `BCS_IRQ_PULSE_NS / `BCS_CLK_PERIOD_NS
) (
   // clock and reset
   input wire clock,
   input wire rstn,
   // register port
   input wire [3:0] addr,
   input wire [7:0] wdata,
   input wire wr,
   input wire rd,
   output reg [7:0] rdata,
   // analog comparator flags
   input wire input_current_loop,
   input wire input_voltage_loop,
   input wire thermal_loop,
   input wire sys_below_batt,
   input wire batt_above_trickle,
   input wire batt_above_pre,
   input wire batt_at_reg,
   input wire ichg_below_term,
   input wire batt_below_recharge,
   input wire input_power_good,
   input wire converter_started,
   input wire boost_active,
   input wire [3:0] thermistor_a_input,
   input wire [3:0] thermistor_b_input,
   // power stage control
   output reg battery_switch,
   output reg charge_on,
   output reg current_reduce,
   output reg voltage_reduce,
   output reg boost_suspend,
   output reg [1:0] zone_current_setting,
   output reg [1:0] zone_voltage_setting,
   output reg [7:0] threshold_levels,
   // pins
   output reg charge_indicator_pin,
   output reg irq_pulse_out,
   output reg irq_pulse_oe
);
   localparam ST_IDLE = 3'h0;
   localparam ST_CHG = 3'h1;
   localparam ST_TOP = 3'h2;
   localparam ST_DONE = 3'h3;
   localparam ST_FLT = 3'h4;

   reg [7:0] ctrl, tmr, therm, thresh, zset, mask;
   reg [19:0] meta, sync;
   reg [2:0] state, next_state;
   reg [2:0] charge_phase_code, thermistor_a_fault, thermistor_b_fault, merged;
   reg [1:0] charge_fault_code;
   reg input_current_loop_flag, input_voltage_loop_flag, topoff_running_flag;
   reg [15:0] tick_cnt, sf_cnt;
   reg [9:0] ms_cnt;
   reg [11:0] top_cnt;
   reg [13:0] irq_cnt;
   reg ms_tick, sec_tick, half_ph, pg_d, en_d, buck_d, pend;
   wire [5:0] zch;
   wire term_held, rech_held;

   wire charge_enable = ctrl[`BCS_CTRL_CHG_EN];
   wire buck_enable = ctrl[`BCS_CTRL_BUCK_EN];
   wire terminate_enable = ctrl[`BCS_CTRL_TERM_EN];
   wire timer_double_enable = ctrl[`BCS_CTRL_TMR2X];
   wire battery_switch_disable = ctrl[`BCS_CTRL_SW_DIS];
   wire pg_or_second_thermistor_select = ctrl[`BCS_CTRL_SEL_B];
   wire register_reset_request = ctrl[`BCS_CTRL_REG_RST];
   wire [1:0] charge_timer_select = tmr[1:0];
   wire [1:0] topoff_duration = tmr[3:2];
   wire [1:0] cool_zone_action = therm[3:2];
   wire [1:0] warm_zone_action = therm[5:4];

   // ----------------------------------------
   // register write side
   // ----------------------------------------
   // the reset request bit self-clears because the default image has it low
   always @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         ctrl <= `BCS_CTRL_RST;
         tmr <= `BCS_TIMER_RST;
         therm <= `BCS_THERM_RST;
         thresh <= `BCS_THRESH_RST;
         zset <= `BCS_ZONESET_RST;
         mask <= `BCS_MASK_RST;
      end else if (register_reset_request) begin
         ctrl <= `BCS_CTRL_RST;
         tmr <= `BCS_TIMER_RST;
         therm <= `BCS_THERM_RST;
         thresh <= `BCS_THRESH_RST;
         zset <= `BCS_ZONESET_RST;
         mask <= `BCS_MASK_RST;
      end else if (wr) begin
         case (addr)
            `BCS_ADDR_CTRL: ctrl <= wdata;
            `BCS_ADDR_TIMER: tmr <= {4'h0, wdata[3:0]};
            `BCS_ADDR_THERM: therm <= {2'h0, wdata[5:0]};
            `BCS_ADDR_THRESH: thresh <= wdata;
            `BCS_ADDR_ZONESET: zset <= {4'h0, wdata[3:0]};
            `BCS_ADDR_MASK: mask <= {5'h00, wdata[2:0]};
            default: ;
         endcase
      end
   end

   // ----------------------------------------
   // register read side
   // ----------------------------------------
   always @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         rdata <= 8'h00;
      end else if (rd) begin
         case (addr)
            `BCS_ADDR_CTRL: rdata <= ctrl;
            `BCS_ADDR_TIMER: rdata <= tmr;
            `BCS_ADDR_THERM: rdata <= therm;
            `BCS_ADDR_THRESH: rdata <= thresh;
            `BCS_ADDR_ZONESET: rdata <= zset;
            `BCS_ADDR_STATUS: rdata <= {charge_fault_code, topoff_running_flag, input_voltage_loop_flag,
                                        input_current_loop_flag, charge_phase_code};
            `BCS_ADDR_ZONES: rdata <= {2'h0, thermistor_b_fault, thermistor_a_fault};
            `BCS_ADDR_MASK: rdata <= mask;
            default: rdata <= 8'h00;
         endcase
      end else begin
         rdata <= 8'h00;
      end
   end

   // ----------------------------------------
   // comparator synchronisers and timebase
   // ----------------------------------------
   always @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         meta <= 20'h00000;
         sync <= 20'h00000;
      end else begin
         meta <= {thermistor_b_input, thermistor_a_input, boost_active, converter_started, input_power_good,
                  batt_below_recharge, ichg_below_term, batt_at_reg, batt_above_pre, batt_above_trickle,
                  sys_below_batt, thermal_loop, input_voltage_loop, input_current_loop};
         sync <= meta;
      end
   end
   wire s_iloop = sync[0];
   wire s_vloop = sync[1];
   wire s_therm = sync[2];
   wire s_sysl = sync[3];
   wire s_tc = sync[4];
   wire s_pre = sync[5];
   wire s_reg = sync[6];
   wire s_term = sync[7];
   wire s_rech = sync[8];
   wire s_pg = sync[9];
   wire s_conv = sync[10];
   wire s_boost = sync[11];

   // deglitch and safety counts all derive from one millisecond tick
   always @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         tick_cnt <= 16'h0000;
         ms_cnt <= 10'h000;
         ms_tick <= 1'b0;
         sec_tick <= 1'b0;
      end else begin
         ms_tick <= (tick_cnt == TICK_CYCLES[15:0] - 16'h0001);
         sec_tick <= ms_tick && (ms_cnt == `BCS_MS_PER_S - 10'h001);
         tick_cnt <= (tick_cnt == TICK_CYCLES[15:0] - 16'h0001) ? 16'h0000 : tick_cnt + 16'h0001;
         if (ms_tick) begin
            ms_cnt <= (ms_cnt == `BCS_MS_PER_S - 10'h001) ? 10'h000 : ms_cnt + 10'h001;
         end
      end
   end

   // ----------------------------------------
   // thermistor zones
   // ----------------------------------------
   // comparator bits per channel: 0 cooler than cool, 1 colder than cold,
   // 2 warmer than warm, 3 hotter than hot
   wire [1:0] ch_en = {therm[`BCS_THERM_B_ACT] & pg_or_second_thermistor_select, therm[`BCS_THERM_A_ACT]};
   genvar g;
   generate
      for (g = 0; g < 2; g = g + 1) begin : g_zone
         wire [3:0] c = sync[12 + 4 * g +: 4];
         // in boost only the outer limits are looked at
         assign zch[3 * g +: 3] = !ch_en[g] ? `BCS_Z_NORMAL :
                                  c[3] ? `BCS_Z_HOT :
                                  c[1] ? `BCS_Z_COLD :
                                  s_boost ? `BCS_Z_NORMAL :
                                  c[2] ? `BCS_Z_WARM :
                                  c[0] ? `BCS_Z_COOL : `BCS_Z_NORMAL;
      end
   endgenerate

   wire zone_change = (zch != {thermistor_b_fault, thermistor_a_fault});
   wire temp_ok = (merged != `BCS_Z_HOT) && (merged != `BCS_Z_COLD);
   wire reduce_cur = ((merged == `BCS_Z_COOL) && cool_zone_action[0]) ||
                     ((merged == `BCS_Z_WARM) && warm_zone_action[0]);

   always @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         thermistor_a_fault <= `BCS_Z_NORMAL;
         thermistor_b_fault <= `BCS_Z_NORMAL;
         merged <= `BCS_Z_NORMAL;
         current_reduce <= 1'b0;
         voltage_reduce <= 1'b0;
         boost_suspend <= 1'b0;
         zone_current_setting <= 2'h0;
         zone_voltage_setting <= 2'h0;
         threshold_levels <= `BCS_THRESH_RST;
      end else begin
         thermistor_a_fault <= zch[2:0];
         thermistor_b_fault <= zch[5:3];
         if (zch[2:0] == `BCS_Z_HOT || zch[5:3] == `BCS_Z_HOT) begin
            merged <= `BCS_Z_HOT;
         end else if (zch[2:0] == `BCS_Z_COLD || zch[5:3] == `BCS_Z_COLD) begin
            merged <= `BCS_Z_COLD;
         end else if (zch[2:0] == `BCS_Z_WARM || zch[5:3] == `BCS_Z_WARM) begin
            merged <= `BCS_Z_WARM;
         end else if (zch[2:0] == `BCS_Z_COOL || zch[5:3] == `BCS_Z_COOL) begin
            merged <= `BCS_Z_COOL;
         end else begin
            merged <= `BCS_Z_NORMAL;
         end
         current_reduce <= reduce_cur;
         voltage_reduce <= ((merged == `BCS_Z_COOL) && cool_zone_action[1]) ||
                           ((merged == `BCS_Z_WARM) && warm_zone_action[1]);
         boost_suspend <= s_boost && !temp_ok;
         zone_current_setting <= zset[1:0];
         zone_voltage_setting <= zset[3:2];
         threshold_levels <= thresh;
      end
   end

   // ----------------------------------------
   // deglitch filters
   // ----------------------------------------
   bcs_deglitch u_term_dgl (
      .clock(clock),
      .rstn(rstn),
      .tick(ms_tick),
      .level(state == ST_CHG && charge_on && s_reg && s_term),
      .limit(`BCS_TERM_DGL_MS),
      .held(term_held)
   );
   bcs_deglitch u_rech_dgl (
      .clock(clock),
      .rstn(rstn),
      .tick(ms_tick),
      .level((state == ST_TOP || state == ST_DONE) && s_pg && s_rech),
      .limit(`BCS_RECH_DGL_MS),
      .held(rech_held)
   );

   // ---------------------------------------------------------------
   // charge sequence
   // ---------------------------------------------------------------
   wire pg_fall = pg_d && !s_pg;
   wire en_rise = charge_enable && !en_d;
   wire sf_clear = pg_fall || (en_d != charge_enable) || (buck_d != buck_enable) || register_reset_request;
   wire loops = s_iloop || s_vloop || s_therm;
   wire term_ok = term_held && terminate_enable && !loops;
   wire start_ok = s_conv && temp_ok && !battery_switch_disable && charge_enable;
   wire [15:0] sf_limit = !s_pre ? `BCS_PRE_TIMER_S :
                          charge_timer_select == 2'h1 ? `BCS_TMR_SEL1_S :
                          charge_timer_select == 2'h2 ? `BCS_TMR_SEL2_S : `BCS_TMR_SEL3_S;
   wire sf_exp = (charge_timer_select != 2'h0) && (sf_cnt >= sf_limit);
   wire [11:0] top_limit = topoff_duration == 2'h1 ? `BCS_TOP1_S :
                           topoff_duration == 2'h2 ? `BCS_TOP2_S : `BCS_TOP3_S;
   wire top_exp = (top_cnt >= top_limit);
   wire stop = !charge_enable || !s_pg;

   always @* begin
      next_state = state;
      case (state)
         ST_IDLE: if (start_ok) next_state = ST_CHG;
         ST_CHG: begin
            if (stop) next_state = ST_IDLE;
            else if (sf_exp) next_state = ST_FLT;
            else if (term_ok) next_state = (topoff_duration != 2'h0) ? ST_TOP : ST_DONE;
         end
         ST_TOP: begin
            if (stop) next_state = ST_IDLE;
            else if (rech_held) next_state = ST_CHG;
            else if (top_exp) next_state = ST_DONE;
         end
         // leaving done needs a replug, an enable toggle or a deglitched recharge
         ST_DONE: begin
            if (stop) next_state = ST_IDLE;
            else if (rech_held) next_state = ST_CHG;
         end
         ST_FLT: if (sf_clear) next_state = ST_IDLE;
         default: next_state = ST_IDLE;
      endcase
   end

   always @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         state <= ST_IDLE;
         pg_d <= 1'b0;
         en_d <= 1'b1;
         buck_d <= 1'b1;
         charge_fault_code <= `BCS_FAULT_NONE;
         charge_phase_code <= `BCS_PH_IDLE;
         topoff_running_flag <= 1'b0;
         charge_on <= 1'b0;
         charge_indicator_pin <= 1'b1;
         battery_switch <= 1'b0;
         input_current_loop_flag <= 1'b0;
         input_voltage_loop_flag <= 1'b0;
      end else begin
         state <= next_state;
         pg_d <= s_pg;
         en_d <= charge_enable;
         buck_d <= buck_enable;
         input_current_loop_flag <= s_iloop;
         input_voltage_loop_flag <= s_vloop;
         if (next_state == ST_FLT) begin
            charge_fault_code <= `BCS_FAULT_TIMER;
         end else begin
            charge_fault_code <= `BCS_FAULT_NONE;
         end
         topoff_running_flag <= (next_state == ST_TOP);
         // thermistor faults hold the state but stop current flowing
         charge_on <= (next_state == ST_CHG || next_state == ST_TOP) && temp_ok && buck_enable && s_conv;
         charge_indicator_pin <= (next_state != ST_CHG);
         battery_switch <= !battery_switch_disable && (!s_pg || s_sysl || charge_on);
         case (next_state)
            ST_CHG: charge_phase_code <= s_reg ? `BCS_PH_CV : s_pre ? `BCS_PH_CC :
                                         s_tc ? `BCS_PH_PRE : `BCS_PH_TRICKLE;
            ST_TOP, ST_DONE: charge_phase_code <= `BCS_PH_DONE;
            default: charge_phase_code <= `BCS_PH_IDLE;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // safety and top-off timers
   // ---------------------------------------------------------------
   wire half_rate = timer_double_enable && (loops || reduce_cur);
   always @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         sf_cnt <= 16'h0000;
         half_ph <= 1'b0;
         top_cnt <= 12'h000;
      end else begin
         if (sf_clear) begin
            sf_cnt <= 16'h0000;
            half_ph <= 1'b0;
         end else if (sec_tick && state == ST_CHG && charge_on) begin
            half_ph <= half_rate ? !half_ph : 1'b0;
            if (!half_rate || half_ph) begin
               sf_cnt <= sf_cnt + 16'h0001;
            end
         end
         if (en_rise || register_reset_request || (state != ST_TOP && next_state == ST_TOP) ||
             (state == ST_TOP && next_state == ST_CHG)) begin
            top_cnt <= 12'h000;
         end else if (sec_tick && state == ST_TOP) begin
            top_cnt <= top_cnt + 12'h001;
         end
      end
   end

   // ---------------------------------------------------------------
   // interrupt pulse
   // ---------------------------------------------------------------
   // events landing during a pulse merge into one follow-up pulse
   wire ev = (s_iloop && !input_current_loop_flag && !mask[`BCS_MASK_ILOOP]) ||
             (s_vloop && !input_voltage_loop_flag && !mask[`BCS_MASK_VLOOP]) ||
             (((next_state == ST_TOP) != topoff_running_flag) && !mask[`BCS_MASK_TOPOFF]) ||
             (state == ST_CHG && (next_state == ST_TOP || next_state == ST_DONE)) ||
             (state != ST_CHG && state != ST_IDLE && next_state == ST_CHG) ||
             (next_state == ST_FLT && state != ST_FLT) || zone_change;
   always @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         irq_cnt <= 14'h0000;
         pend <= 1'b0;
         irq_pulse_oe <= 1'b0;
         irq_pulse_out <= 1'b0;
      end else begin
         irq_pulse_out <= 1'b0;
         if (irq_cnt == 14'h0000) begin
            if (ev || pend) begin
               irq_cnt <= IRQ_CYCLES[13:0];
               irq_pulse_oe <= 1'b1;
               pend <= 1'b0;
            end else begin
               irq_pulse_oe <= 1'b0;
            end
         end else begin
            irq_cnt <= irq_cnt - 14'h0001;
            irq_pulse_oe <= (irq_cnt != 14'h0001);
            if (ev) begin
               pend <= 1'b1;
            end
         end
      end
   end
endmodule

// file: test/bcs_charge_seq_monitor.sv
`timescale 1ns/10ps
`include "bcs_regs.vh"
// ----------------------------------------
// port checks of the sequencer
// ----------------------------------------
module bcs_charge_seq_monitor #(
   parameter IRQ_CYCLES = 8
) (
   // clock and reset
   input wire logic clock,
   input wire logic rstn,
   // register writes
   input wire logic [3:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr,
   // comparator flags
   input wire logic converter_started,
   input wire logic boost_active,
   input wire logic [3:0] thermistor_a_input,
   // outputs
   input wire logic charge_on,
   input wire logic boost_suspend,
   input wire logic [7:0] threshold_levels,
   input wire logic irq_pulse_out,
   input wire logic irq_pulse_oe
);
   int run;
   default clocking @(posedge clock); endclocking
   default disable iff (!rstn);
   always @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         run <= 0;
      end else begin
         run <= irq_pulse_oe ? run + 1 : 0;
      end
   end
   sequence hot_held;
      thermistor_a_input[3] [*6];
   endsequence
   sequence thresh_wr;
      wr && addr == `BCS_ADDR_THRESH ##1 !(wr && addr == `BCS_ADDR_THRESH);
   endsequence
   chk_hot_stop: assert property (hot_held |-> !charge_on)
      else $error("charging while hot");
   chk_cold_stop: assert property (thermistor_a_input[1] [*6] |-> !charge_on)
      else $error("charging while cold");
   chk_start_gate: assert property (!converter_started [*6] |-> !charge_on)
      else $error("charging without converter");
   chk_boost_hot: assert property ((boost_active && thermistor_a_input[3]) [*6] |-> boost_suspend)
      else $error("boost not suspended");
   chk_boost_idle: assert property (!boost_active [*6] |-> !boost_suspend)
      else $error("suspend outside boost");
   chk_thresh_copy: assert property (thresh_wr |=> threshold_levels == $past(wdata, 2))
      else $error("threshold copy wrong");
   chk_irq_level: assert property (irq_pulse_oe |-> !irq_pulse_out)
      else $error("interrupt pin not low");
   chk_irq_width: assert property ($fell(irq_pulse_oe) |-> run == IRQ_CYCLES)
      else $error("interrupt pulse length wrong");
endmodule
bind bcs_charge_seq bcs_charge_seq_monitor #(.IRQ_CYCLES(IRQ_CYCLES)) bcs_charge_seq_monitor_i (
   .clock, .rstn, .addr, .wdata, .wr, .converter_started, .boost_active, .thermistor_a_input,
   .charge_on, .boost_suspend, .threshold_levels, .irq_pulse_out, .irq_pulse_oe);

// file: test/bcs_host_model.sv
`timescale 1ns/10ps
// ----------------------------------------
// host side of the register port
// ----------------------------------------
module bcs_host_model (
   // clock
   input wire logic clock,
   // register port
   output logic [3:0] addr = '0,
   output logic [7:0] wdata = '0,
   output logic wr = '0,
   output logic rd = '0,
   input wire logic [7:0] rdata
);
   // callers enter just after a rising edge
   task automatic write(input logic [3:0] a, input logic [7:0] d);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clock);
      wr <= 1'b0;
      @(posedge clock);
   endtask
   task automatic read(input logic [3:0] a, output logic [7:0] d);
      addr <= a;
      rd <= 1'b1;
      @(posedge clock);
      rd <= 1'b0;
      @(posedge clock);
      d = rdata;
   endtask
   // an enable toggle restarts a finished cycle, as do a replug or a recharge
   task automatic restart(input logic [7:0] ctrl);
      write(4'h0, ctrl & 8'hFE);
      write(4'h0, ctrl);
   endtask
endmodule

// file: test/tb_top.sv
`timescale 1ns/10ps
`include "bcs_regs.vh"
module tb_top;
   logic clock = '0, rstn = '0, input_current_loop = '0, input_voltage_loop = '0, thermal_loop = '0;
   logic sys_below_batt = '0, batt_above_trickle = '0, batt_above_pre = '0, batt_at_reg = '0;
   logic ichg_below_term = '0, batt_below_recharge = '0, input_power_good = '0, converter_started = '0;
   logic boost_active = '0, wr, rd, battery_switch, charge_on, current_reduce, voltage_reduce;
   logic boost_suspend, charge_indicator_pin, irq_pulse_out, irq_pulse_oe;
   logic [3:0] thermistor_a_input = '0, thermistor_b_input = '0, addr;
   logic [1:0] zone_current_setting, zone_voltage_setting;
   logic [7:0] wdata, rdata, threshold_levels, v, r;
   logic [7:0] rv [9] = '{`BCS_CTRL_RST, `BCS_TIMER_RST, `BCS_THERM_RST, `BCS_THRESH_RST,
      `BCS_ZONESET_RST, 8'h00, 8'h00, `BCS_MASK_RST, 8'h00};
   int mismatches = 0, n_compared = 0, n_irq = 0, n0, k;
   // open-drain line with its pull-up
   wire irq_n = irq_pulse_oe ? irq_pulse_out : 1'b1;
   always #10 clock = ~clock;
   always @(negedge irq_n) n_irq++;
   bcs_charge_seq #(.TICK_CYCLES(10), .IRQ_CYCLES(8)) bcs_charge_seq_i (.clock, .rstn, .addr, .wdata, .wr, .rd,
      .rdata, .input_current_loop, .input_voltage_loop, .thermal_loop, .sys_below_batt, .batt_above_trickle,
      .batt_above_pre, .batt_at_reg, .ichg_below_term, .batt_below_recharge, .input_power_good,
      .converter_started, .boost_active, .thermistor_a_input, .thermistor_b_input, .battery_switch,
      .charge_on, .current_reduce, .voltage_reduce, .boost_suspend, .zone_current_setting,
      .zone_voltage_setting, .threshold_levels, .charge_indicator_pin, .irq_pulse_out, .irq_pulse_oe);
   bcs_host_model bcs_host_model_i (.clock, .addr, .wdata, .wr, .rd, .rdata);
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      n_compared++;
      if (seen !== exp) begin
         mismatches++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic wait_n(input int n);
      repeat (n) @(posedge clock);
   endtask
   function automatic logic [7:0] phase_of(input int n);
      return {5'h0, n > 2 ? `BCS_PH_CV : n > 1 ? `BCS_PH_CC : n > 0 ? `BCS_PH_PRE : `BCS_PH_TRICKLE};
   endfunction
   task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp, input logic [7:0] m);
      bcs_host_model_i.read(a, v);
      check(v & m, exp);
   endtask
   task automatic test_done;
      $display("mismatches=%0d compared=%0d", mismatches, n_compared);
      if (mismatches == 0 && n_compared > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   // tests take about 4000 cycles
   initial begin
      #(20 * 20000);
      mismatches++;
      test_done;
   end
   initial begin
      void'($urandom(32'h7B8C));
      wait_n(6);
      rstn <= 1'b1;
      wait_n(1);
      for (k = 0; k < 9; k++) rd_chk(4'(k), rv[k], 8'hFF);
      for (k = 0; k < 8; k++) begin
         r = 8'($urandom);
         bcs_host_model_i.write(`BCS_ADDR_THRESH, r);
         bcs_host_model_i.write(`BCS_ADDR_ZONESET, {4'h0, r[3:0]});
         wait_n(2);
         check(threshold_levels, r);
         check({4'h0, zone_voltage_setting, zone_current_setting}, {4'h0, r[3:0]});
         {thermal_loop, input_voltage_loop, input_current_loop} <= 3'($urandom);
         wait_n(5);
         rd_chk(`BCS_ADDR_STATUS, {3'h0, input_voltage_loop, input_current_loop, 3'h0}, 8'h18);
      end
      {thermal_loop, input_voltage_loop, input_current_loop} <= 3'h0;
      input_power_good <= 1'b1;
      sys_below_batt <= 1'b1;
      wait_n(10);
      check(8'(battery_switch), 8'h01);
      converter_started <= 1'b1;
      sys_below_batt <= 1'b0;
      for (k = 0; k < 4; k++) begin
         {batt_at_reg, batt_above_pre, batt_above_trickle} <= 3'((1 << k) - 1);
         wait_n(6);
         rd_chk(`BCS_ADDR_STATUS, phase_of(k), 8'h07);
      end
      check(8'(charge_on), 8'h01);
      check(8'(charge_indicator_pin), 8'h00);
      n0 = n_irq;
      ichg_below_term <= 1'b1;
      wait_n(2400);
      rd_chk(`BCS_ADDR_STATUS, `BCS_PH_CV, 8'h07);
      wait_n(200);
      rd_chk(`BCS_ADDR_STATUS, `BCS_PH_DONE, 8'h07);
      check(8'(charge_indicator_pin), 8'h01);
      check(8'(n_irq - n0), 8'h01);
      n0 = n_irq;
      {batt_at_reg, ichg_below_term, batt_below_recharge} <= 3'h1;
      wait_n(1200);
      rd_chk(`BCS_ADDR_STATUS, `BCS_PH_CC, 8'h07);
      check(8'(n_irq - n0), 8'h01);
      batt_below_recharge <= 1'b0;
      bcs_host_model_i.restart(`BCS_CTRL_RST);
      wait_n(6);
      rd_chk(`BCS_ADDR_STATUS, `BCS_PH_CC, 8'h07);
      // cool cuts current, warm cuts voltage
      bcs_host_model_i.write(`BCS_ADDR_CTRL, 8'h2F);
      bcs_host_model_i.write(`BCS_ADDR_THERM, 8'h27);
      {thermistor_b_input, thermistor_a_input} <= 8'h41;
      wait_n(6);
      rd_chk(`BCS_ADDR_ZONES, {2'h0, `BCS_Z_WARM, `BCS_Z_COOL}, 8'h3F);
      check({6'h0, current_reduce, voltage_reduce}, 8'h01);
      thermistor_b_input <= 4'h8;
      wait_n(6);
      check(8'(charge_on), 8'h00);
      bcs_host_model_i.write(`BCS_ADDR_CTRL, 8'h0F);
      wait_n(6);
      rd_chk(`BCS_ADDR_ZONES, {5'h0, `BCS_Z_COOL}, 8'h3F);
      check({6'h0, current_reduce, voltage_reduce}, 8'h02);
      check(8'(charge_on), 8'h01);
      {converter_started, input_power_good, boost_active} <= 3'h1;
      for (k = 0; k < 3; k++) begin
         thermistor_a_input <= k == 0 ? 4'h8 : k == 1 ? 4'h2 : 4'h1;
         wait_n(8);
         check(8'(boost_suspend), 8'(k < 2));
         rd_chk(`BCS_ADDR_ZONES, {5'h0, k == 0 ? `BCS_Z_HOT : k == 1 ? `BCS_Z_COLD : `BCS_Z_NORMAL}, 8'h07);
      end
      test_done;
   end
endmodule
